//--- src/bcs_map.vh
// Constants for the encoder commutation and speed loop block.
// Assumes a 10 MHz system clock and a classic Wishbone slave port.
`ifndef BCS_MAP_VH
`define BCS_MAP_VH

// Register byte offsets
`define BCS_REG_CTRL      8'h00
`define BCS_REG_STATUS    8'h04
`define BCS_REG_POS       8'h08
`define BCS_REG_CMP_LO    8'h0C
`define BCS_REG_CMP_HI    8'h10
`define BCS_REG_SECTOR    8'h14
`define BCS_REG_SPD_REQ   8'h18
`define BCS_REG_SPD_ACT   8'h1C
`define BCS_REG_GAIN_P    8'h20
`define BCS_REG_GAIN_I    8'h24
`define BCS_REG_DUTY      8'h28
`define BCS_REG_SAMPLE    8'h2C

// Control fields
`define BCS_CTRL_EN_BIT      0
`define BCS_CTRL_ALIGN_BIT   1
`define BCS_CTRL_CLR_BIT     2
`define BCS_CTRL_LOOP_BIT    3
`define BCS_CTRL_DIRNEG_BIT  4
`define BCS_CTRL_RESET       8'h00

// Status fields
`define BCS_STAT_EVT_BIT     0
`define BCS_STAT_DIR_BIT     1

// Encoder geometry: 500 lines, four counts each, two pole pairs
`define BCS_ENC_LINES        500
`define BCS_COUNTS_PER_LINE  4
`define BCS_POLE_PAIRS       2
`define BCS_COUNTS_PER_ELEC  ((`BCS_ENC_LINES * `BCS_COUNTS_PER_LINE) / `BCS_POLE_PAIRS)
`define BCS_SECTORS          6
`define BCS_DEG_PER_SECTOR   60

// PWM and speed loop
`define BCS_PWM_PERIOD       16'h03E8
`define BCS_DUTY_MAX         16'h03E8
`define BCS_SAMPLE_RESET     16'h2710
`define BCS_GAIN_P_RESET     16'h0010
`define BCS_GAIN_I_RESET     16'h0001
`define BCS_DEAD_CYCLES      4'h2

`endif

//--- src/bcs_quad_dec.v
// Quadrature decoder with position counter and two border compares.
// Assumes encoder inputs already synchronous to sys_clk.
`timescale 1ns/1ps
module bcs_quad_dec (
	input  wire        sys_clk,
	input  wire        rst,
	input  wire        enc_a,
	input  wire        enc_b,
	input  wire        enc_index,
	input  wire        pos_clear,
	input  wire [15:0] cmp_lo,
	input  wire [15:0] cmp_hi,
	output reg  [15:0] pos_r,
	output reg         dir_r,
	output reg         hit_r,
	output reg         index_seen_r
);
	reg  [1:0] ab_r;
	wire [1:0] ab_now = {enc_a, enc_b};
	wire       step   = (ab_now[0] ^ ab_r[0]) ^ (ab_now[1] ^ ab_r[1]);
	wire       up     = ab_r[1] ^ ab_now[0];
	reg  [15:0] pos_nxt;

	// Every edge of either phase counts, four counts per line
	always @* begin
		pos_nxt = pos_r;
		if (step)
			pos_nxt = up ? pos_r + 16'h0001 : pos_r - 16'h0001; // R7
	end

	// Event only on reaching a border, quiet while strictly between
	always @(posedge sys_clk) begin
		if (rst) begin
			ab_r         <= ab_now; // Follow the pins so leaving reset counts no edge
			pos_r        <= 16'h0000;
			dir_r        <= 1'b0;
			hit_r        <= 1'b0;
			index_seen_r <= 1'b0;
		end else begin
			ab_r  <= ab_now; // R6
			hit_r <= 1'b0;
			if (enc_index)
				index_seen_r <= 1'b1; // R6
			if (pos_clear) begin
				pos_r <= 16'h0000;
			end else if (step) begin
				pos_r <= pos_nxt;
				dir_r <= up; // R19
				hit_r <= (pos_nxt == cmp_lo) || (pos_nxt == cmp_hi); // R9 R12
			end
		end
	end
endmodule // bcs_quad_dec

//--- src/bcs_pi_ctrl.v
// Discrete PI speed controller with clamped output and integrator.
// Assumes the caller pulses sample once per sampling period.
`timescale 1ns/1ps
`include "bcs_map.vh"
module bcs_pi_ctrl (
	input  wire        sys_clk,
	input  wire        rst,
	input  wire        sample,
	input  wire [15:0] spd_req,
	input  wire [15:0] spd_act,
	input  wire [15:0] gain_p,
	input  wire [15:0] gain_i,
	output reg  [15:0] duty_r
);
	reg  signed [31:0] integ_r;
	wire signed [16:0] err   = $signed({1'b0, spd_req}) - $signed({1'b0, spd_act});
	wire signed [33:0] p_term = err * $signed({1'b0, gain_p});
	wire signed [33:0] i_inc  = err * $signed({1'b0, gain_i});
	wire signed [33:0] i_sum  = integ_r + i_inc;
	reg  signed [33:0] i_nxt;
	reg  signed [33:0] u_sum;

	// Clamp to the duty range so the integrator cannot wind up
	function [33:0] clamp;
		input signed [33:0] v;
		begin
			if (v < 0)
				clamp = 34'h0;
			else if (v > $signed({18'h0, `BCS_DUTY_MAX}))
				clamp = {18'h0, `BCS_DUTY_MAX};
			else
				clamp = v;
		end
	endfunction

	// u = Kc*e plus running integral of Kc*T/Ti*e (gain_i holds that product)
	always @* begin
		i_nxt = clamp(i_sum); // R17 R20
		u_sum = clamp(p_term + i_nxt); // R16 R17 R20
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			integ_r <= 32'h0;
			duty_r  <= 16'h0;
		end else if (sample) begin
			integ_r <= i_nxt[31:0];
			duty_r  <= u_sum[15:0];
		end
	end
endmodule // bcs_pi_ctrl

//--- src/bcs_commutator.v
// Functional notes
// R1: Exactly two phases driven at once, third left floating; six vectors.
// R2: Driven legs switch high and low transistors as complementary bipolar pairs.
// R3: Commutate every 60 electrical degrees with accurate angular timing.
// R4: Sector 110 drives A high, C low, B floats; 100 applies new pattern.
// R5: One electrical revolution of counts split into six equal sectors.
// R6: Decoder takes phase A, phase B and index inputs.
// R7: Count both edges of both phases, four counts per line.
// R8: Software clears the counter and loads sector borders after alignment.
// R9: No event while counter is strictly between the two compares.
// R10: Software reloads borders of next sector by spin direction.
// R11: Software updates the sector word then applies the new pattern.
// R12: Six events per electrical revolution, at sensor commutation instants.
// R13: Software applies a static alignment pattern once before first start.
// R14: Software sets borders plus and minus 30 degrees around alignment.
// R15: First vector orthogonal to alignment; voltage sign picks direction.
// R16: PI on speed error sets PWM duty, the applied voltage.
// R17: Output is Kc*e plus integral plus Kc*T/Ti*e each sample.
// R18: Signal the host whenever the counter reaches a sector border.
// R19: Spin direction taken from decoder count direction at the border.
// R20: Clamp PI output and integral to the duty range.
//
// Top of the BLDC commutation and speed loop block, a Wishbone slave.
// Assumes encoder pins synchronous to the 10 MHz sys_clk.
// Speed reads wrong if the rotor moves more than 32768 counts in one sample period.
`timescale 1ns/1ps
`include "bcs_map.vh"
module bcs_commutator (
	input  wire        sys_clk,
	input  wire        rst,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire        enc_a,
	input  wire        enc_b,
	input  wire        enc_index,
	output reg         phase_a_high_switch,
	output reg         phase_a_low_switch,
	output reg         phase_b_high_switch,
	output reg         phase_b_low_switch,
	output reg         phase_c_high_switch,
	output reg         phase_c_low_switch,
	output wire        pos_event
);
	// Software visible registers
	reg  [7:0]  ctrl_r;
	reg  [2:0]  sector_r;
	reg  [15:0] cmp_lo_r;
	reg  [15:0] cmp_hi_r;
	reg  [15:0] spd_req_r;
	reg  [15:0] gain_p_r;
	reg  [15:0] gain_i_r;
	reg  [15:0] sample_per_r;
	reg         evt_r;
	reg         clr_pulse_r;

	// Speed measurement and PWM state
	reg  [15:0] smp_cnt_r;
	reg         smp_tick_r;
	reg  [15:0] pos_last_r;
	reg  [15:0] spd_act_r;
	reg  [15:0] pwm_cnt_r;
	reg  [15:0] duty_eff_r;
	reg  [3:0]  dead_cnt_r;
	reg         pwm_hi_r;
	// Sector pattern, registered so a change of it can arm the dead band
	reg  [5:0]  pat_r;
	reg  [5:0]  pat_nxt;

	// Decoder and speed loop results
	wire [15:0] pos;
	wire        dir;
	wire        hit;
	wire        idx_seen;
	wire [15:0] duty_pi;
	wire [15:0] pos_delta = pos - pos_last_r;

	// Ack masks the held request, so each cycle is taken exactly once
	wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wb_wr  = wb_req & wb_we_i;
	wire wb_rd  = wb_req & ~wb_we_i;

	// Position counter with the two border compares
	bcs_quad_dec u_dec (
		.sys_clk      (sys_clk),
		.rst          (rst),
		.enc_a        (enc_a),
		.enc_b        (enc_b),
		.enc_index    (enc_index),
		.pos_clear    (clr_pulse_r),
		.cmp_lo       (cmp_lo_r),
		.cmp_hi       (cmp_hi_r),
		.pos_r        (pos),
		.dir_r        (dir),
		.hit_r        (hit),
		.index_seen_r (idx_seen)
	);

	// Integrator runs on every tick even in open loop; closing the loop starts warm
	bcs_pi_ctrl u_pi (
		.sys_clk (sys_clk),
		.rst     (rst),
		.sample  (smp_tick_r),
		.spd_req (spd_req_r),
		.spd_act (spd_act_r),
		.gain_p  (gain_p_r),
		.gain_i  (gain_i_r),
		.duty_r  (duty_pi)
	);

	// Byte lane merge for a 16-bit register
	function [15:0] merge16;
		input [15:0] old;
		input [31:0] dat;
		input [3:0]  sel;
		begin
			merge16[7:0]  = sel[0] ? dat[7:0]  : old[7:0];
			merge16[15:8] = sel[1] ? dat[15:8] : old[15:8];
		end
	endfunction

	// Magnitude of a wrapping position difference; the count rolls over zero
	// when the rotor turns back past the cleared position
	function [15:0] mag16;
		input [15:0] d;
		begin
			mag16 = d[15] ? 16'h0000 - d : d;
		end
	endfunction

	// Host sees a level for each border reached
	assign pos_event = evt_r; // R18

	// Register writes; a new border hit wins over a clear in the same cycle
	always @(posedge sys_clk) begin
		if (rst) begin
			ctrl_r       <= `BCS_CTRL_RESET;
			sector_r     <= 3'h0;
			cmp_lo_r     <= 16'h0;
			cmp_hi_r     <= 16'h0;
			spd_req_r    <= 16'h0;
			gain_p_r     <= `BCS_GAIN_P_RESET;
			gain_i_r     <= `BCS_GAIN_I_RESET;
			sample_per_r <= `BCS_SAMPLE_RESET;
			evt_r        <= 1'b0;
			clr_pulse_r  <= 1'b0;
		end else begin
			// Counter clear is a one-cycle strobe
			clr_pulse_r <= 1'b0;
			if (wb_wr) begin
				case (wb_adr_i)
				`BCS_REG_CTRL: begin
					if (wb_sel_i[0]) begin
						ctrl_r      <= wb_dat_i[7:0];
						ctrl_r[`BCS_CTRL_CLR_BIT] <= 1'b0;
						clr_pulse_r <= wb_dat_i[`BCS_CTRL_CLR_BIT]; // R8
					end
				end
				`BCS_REG_CMP_LO:  cmp_lo_r     <= merge16(cmp_lo_r, wb_dat_i, wb_sel_i);
				`BCS_REG_CMP_HI:  cmp_hi_r     <= merge16(cmp_hi_r, wb_dat_i, wb_sel_i);
				`BCS_REG_SECTOR: begin
					if (wb_sel_i[0])
						sector_r <= wb_dat_i[2:0]; // R11
				end
				`BCS_REG_SPD_REQ: spd_req_r    <= merge16(spd_req_r, wb_dat_i, wb_sel_i);
				`BCS_REG_GAIN_P:  gain_p_r     <= merge16(gain_p_r, wb_dat_i, wb_sel_i);
				`BCS_REG_GAIN_I:  gain_i_r     <= merge16(gain_i_r, wb_dat_i, wb_sel_i);
				`BCS_REG_SAMPLE:  sample_per_r <= merge16(sample_per_r, wb_dat_i, wb_sel_i);
				default: ;
				endcase
			end
			// Write one to the event bit clears it
			if (wb_wr && wb_adr_i == `BCS_REG_STATUS && wb_sel_i[0] &&
			    wb_dat_i[`BCS_STAT_EVT_BIT])
				evt_r <= 1'b0;
			if (hit && ctrl_r[`BCS_CTRL_EN_BIT])
				evt_r <= 1'b1; // R9 R18
		end
	end

	// Single wait state read answer; unmapped addresses read zero
	// Read data stays until the next read, so a slow master still sees it
	always @(posedge sys_clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_rd) begin
				case (wb_adr_i)
				`BCS_REG_CTRL:    wb_dat_o <= {24'h0, ctrl_r};
				`BCS_REG_STATUS:  wb_dat_o <= {29'h0, idx_seen, dir, evt_r};
				`BCS_REG_POS:     wb_dat_o <= {16'h0, pos};
				`BCS_REG_CMP_LO:  wb_dat_o <= {16'h0, cmp_lo_r};
				`BCS_REG_CMP_HI:  wb_dat_o <= {16'h0, cmp_hi_r};
				`BCS_REG_SECTOR:  wb_dat_o <= {29'h0, sector_r};
				`BCS_REG_SPD_REQ: wb_dat_o <= {16'h0, spd_req_r};
				`BCS_REG_SPD_ACT: wb_dat_o <= {16'h0, spd_act_r};
				`BCS_REG_GAIN_P:  wb_dat_o <= {16'h0, gain_p_r};
				`BCS_REG_GAIN_I:  wb_dat_o <= {16'h0, gain_i_r};
				`BCS_REG_DUTY:    wb_dat_o <= {16'h0, duty_eff_r};
				`BCS_REG_SAMPLE:  wb_dat_o <= {16'h0, sample_per_r};
				default:          wb_dat_o <= 32'h0;
				endcase
			end
		end
	end

	// Speed is counts moved per sample period, magnitude only
	// A tick also strobes the PI controller, one step per period
	always @(posedge sys_clk) begin
		if (rst) begin
			smp_cnt_r  <= 16'h0;
			smp_tick_r <= 1'b0;
			pos_last_r <= 16'h0;
			spd_act_r  <= 16'h0;
		end else begin
			smp_tick_r <= 1'b0;
			if (smp_cnt_r >= sample_per_r) begin
				smp_cnt_r  <= 16'h0;
				smp_tick_r <= 1'b1;
				pos_last_r <= pos;
				spd_act_r  <= mag16(pos_delta);
			end else begin
				smp_cnt_r <= smp_cnt_r + 16'h0001;
			end
		end
	end

	// Duty: PI output when the loop is closed, else the requested value open loop
	always @(posedge sys_clk) begin
		if (rst) begin
			duty_eff_r <= 16'h0;
		end else if (ctrl_r[`BCS_CTRL_LOOP_BIT]) begin
			duty_eff_r <= duty_pi; // R16
		end else begin
			duty_eff_r <= (spd_req_r > `BCS_DUTY_MAX) ? `BCS_DUTY_MAX : spd_req_r;
		end
	end

	// Carrier and dead band; a short gap on every edge avoids shoot-through
	always @(posedge sys_clk) begin
		if (rst) begin
			pwm_cnt_r  <= 16'h0;
			pwm_hi_r   <= 1'b0;
			dead_cnt_r <= 4'h0;
			pat_r      <= 6'h00;
		end else begin
			pwm_cnt_r <= (pwm_cnt_r >= `BCS_PWM_PERIOD - 16'h0001) ? 16'h0 :
			             pwm_cnt_r + 16'h0001;
			pat_r     <= pat_nxt;
			if ((pwm_cnt_r < duty_eff_r) != pwm_hi_r) begin
				pwm_hi_r   <= (pwm_cnt_r < duty_eff_r); // R2
				dead_cnt_r <= `BCS_DEAD_CYCLES;
			end else if (pat_nxt != pat_r) begin
				// A sign flip swaps both switches of a leg; open them both first
				dead_cnt_r <= `BCS_DEAD_CYCLES; // R2
			end else if (dead_cnt_r != 4'h0) begin
				dead_cnt_r <= dead_cnt_r - 4'h1;
			end
		end
	end

	// Forward walk 110, 100, 101, 001, 011, 010: neighbours share one driven leg,
	// but a sign flip reverses both driven legs at once, hence the pattern dead band.
	// Pattern for a sector: {A,B,C} leg states, 2'b01 pos, 2'b10 neg, 2'b00 float.
	// Sector word is the equivalent sensor state; the direction bit flips polarity.
	function [5:0] pattern;
		input [2:0] st;
		input       neg;
		reg   [5:0] p;
		begin
			case (st)
			3'b110:  p = 6'b01_00_10; // R4
			3'b100:  p = 6'b01_10_00; // R4
			3'b101:  p = 6'b00_10_01;
			3'b001:  p = 6'b10_00_01;
			3'b011:  p = 6'b10_01_00;
			3'b010:  p = 6'b00_01_10;
			default: p = 6'b00_00_00;
			endcase
			pattern = neg ? {p[4], p[5], p[2], p[3], p[0], p[1]} : p; // R15
		end
	endfunction

	// Drive one leg: float both off, driven legs complementary with dead band
	function [1:0] leg;
		input [1:0] mode;
		input       hi;
		input       dead;
		begin
			case (mode)
			2'b01:   leg = dead ? 2'b00 : {hi, ~hi};  // R2
			2'b10:   leg = dead ? 2'b00 : {~hi, hi};  // R2
			default: leg = 2'b00;                     // R1
			endcase
		end
	endfunction

	// Leg drive, worked out each cycle from the registered pattern
	reg       dead;
	reg [1:0] la;
	reg [1:0] lb;
	reg [1:0] lc;

	// Exactly two legs energized per sector, one per 60 degrees
	always @* begin
		pat_nxt = 6'b00_00_00; // R1
		if (ctrl_r[`BCS_CTRL_EN_BIT])
			pat_nxt = pattern(sector_r, ctrl_r[`BCS_CTRL_DIRNEG_BIT]); // R1 R3 R5
		dead    = (dead_cnt_r != 4'h0);
		la      = leg(pat_r[5:4], pwm_hi_r, dead);
		lb      = leg(pat_r[3:2], pwm_hi_r, dead);
		lc      = leg(pat_r[1:0], pwm_hi_r, dead);
	end

	// Gate outputs registered so they never glitch
	always @(posedge sys_clk) begin
		if (rst) begin
			phase_a_high_switch <= 1'b0;
			phase_a_low_switch  <= 1'b0;
			phase_b_high_switch <= 1'b0;
			phase_b_low_switch  <= 1'b0;
			phase_c_high_switch <= 1'b0;
			phase_c_low_switch  <= 1'b0;
		end else begin
			phase_a_high_switch <= la[1];
			phase_a_low_switch  <= la[0];
			phase_b_high_switch <= lb[1];
			phase_b_low_switch  <= lb[0];
			phase_c_high_switch <= lc[1];
			phase_c_low_switch  <= lc[0];
		end
	end
endmodule // bcs_commutator

//--- testbench/bcs_assertions.sv
// Checker: gate safety, bus answers and the border event flag.
// Assumes it is bound to bcs_commutator and sees only its ports.
`timescale 1ns/1ps
`include "bcs_map.vh"
module bcs_chk (
	input logic        sys_clk,
	input logic        rst,
	input logic        wb_cyc_i,
	input logic        wb_stb_i,
	input logic        wb_we_i,
	input logic [7:0]  wb_adr_i,
	input logic [3:0]  wb_sel_i,
	input logic [31:0] wb_dat_i,
	input logic [31:0] wb_dat_o,
	input logic        wb_ack_o,
	input logic        enc_a,
	input logic        enc_b,
	input logic        enc_index,
	input logic        phase_a_high_switch,
	input logic        phase_a_low_switch,
	input logic        phase_b_high_switch,
	input logic        phase_b_low_switch,
	input logic        phase_c_high_switch,
	input logic        phase_c_low_switch,
	input logic        pos_event
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	// Gate groups, encoder pair and the write that clears the event
	wire [2:0] hi_on = {phase_a_high_switch, phase_b_high_switch, phase_c_high_switch};
	wire [2:0] lo_on = {phase_a_low_switch, phase_b_low_switch, phase_c_low_switch};
	wire [1:0] ab = {enc_a, enc_b};
	wire       wr_clr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
		&& wb_dat_i[0] && (wb_adr_i == `BCS_REG_STATUS);

	// A fresh request, then a single-cycle answer
	sequence req_taken;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence ack_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	// Decode takes two cycles, so motion is looked for a few samples back
	sequence enc_moved;
		$past(ab) != $past(ab, 2) || $past(ab, 2) != $past(ab, 3) || $past(ab, 3) != $past(ab, 4);
	endsequence

	leg_excl_a: assert property ((hi_on & lo_on) == 3'h0)
		else $error("high and low switch of one leg on together");
	two_phase_a: assert property ($countones(hi_on | lo_on) <= 2)
		else $error("more than two legs driven");
	dead_high_a: assert property ($fell(phase_a_high_switch) |-> (!phase_a_low_switch) [*2])
		else $error("leg a low switch on inside dead band");
	dead_low_a: assert property ($fell(phase_c_low_switch) |-> (!phase_c_high_switch) [*2])
		else $error("leg c high switch on inside dead band");
	ack_answer_a: assert property (req_taken |=> ack_pulse)
		else $error("request not answered by one ack pulse");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	event_cause_a: assert property ($rose(pos_event) |-> enc_moved)
		else $error("event raised with no encoder motion");
	event_hold_a: assert property (pos_event && !wr_clr |=> pos_event)
		else $error("event flag dropped without a clear");
endmodule // bcs_chk

//--- testbench/bcs_enc_model.sv
// Encoder model: two quadrature phases and an index pulse.
// Assumes a step is asked only while busy is low; lag delays the answer.
`timescale 1ns/1ps
module bcs_enc_model (
	input  logic       sys_clk,
	input  logic       step,
	input  logic       up,
	input  logic [3:0] lag,
	output logic       enc_a,
	output logic       enc_b,
	output logic       enc_index,
	output logic       busy
);
	logic [1:0]  ph_r = 2'h0;
	logic [15:0] cnt_r = 16'h0000;
	logic [3:0]  wait_r = 4'h0;

	// Gray order 00,01,11,10 counts up, so only one phase moves a step
	assign enc_a = ph_r[1];
	assign enc_b = ph_r[1] ^ ph_r[0];
	assign enc_index = (cnt_r == 16'h0000); // Zero of the model's count

	// Prompt or slow: a step lands lag plus one cycles after it is asked
	initial busy = 1'b0;
	always @(posedge sys_clk) begin
		if (!busy && step) begin
			busy <= 1'b1;
			wait_r <= lag;
		end else if (busy && wait_r != 4'h0) begin
			wait_r <= wait_r - 4'h1;
		end else if (busy) begin
			busy <= 1'b0;
			ph_r <= up ? ph_r + 2'h1 : ph_r - 2'h1;
			cnt_r <= up ? cnt_r + 16'h0001 : cnt_r - 16'h0001;
		end
	end
endmodule // bcs_enc_model

//--- testbench/tb.sv
// Bench top: Wishbone master, encoder model and checks for the block.
// Assumes design sources, checker and encoder model compiled first.
`timescale 1ns/1ps
`include "bcs_map.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
	$display("wrong value %s expected %0h seen %0h", n, e, g); end end
module tb;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h00000000;
	logic [31:0] wb_dat_o, rq;
	logic        wb_ack_o, enc_a, enc_b, enc_index, pos_event, busy;
	logic        phase_a_high_switch, phase_a_low_switch, phase_b_high_switch;
	logic        phase_b_low_switch, phase_c_high_switch, phase_c_low_switch;
	logic        stp = 1'b0;
	logic        up = 1'b1;
	logic [3:0]  lag = 4'h0;
	logic [15:0] lo, hi;
	wire  [5:0]  gt = {phase_a_high_switch, phase_a_low_switch, phase_b_high_switch,
		phase_b_low_switch, phase_c_high_switch, phase_c_low_switch};
	int          errors = 0;
	int          checks = 0;
	int          cyc = 0;
	int          p, nr, last;
	bit          ev;
	logic [2:0]  sq [6] = '{3'h6, 3'h4, 3'h5, 3'h1, 3'h3, 3'h2};

	bcs_commutator bcs_commutator_i (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .enc_a(enc_a),
		.enc_b(enc_b), .enc_index(enc_index), .phase_a_high_switch(phase_a_high_switch),
		.phase_a_low_switch(phase_a_low_switch), .phase_b_high_switch(phase_b_high_switch),
		.phase_b_low_switch(phase_b_low_switch), .phase_c_high_switch(phase_c_high_switch),
		.phase_c_low_switch(phase_c_low_switch), .pos_event(pos_event));
	bcs_enc_model bcs_enc_model_i (.sys_clk(sys_clk), .step(stp), .up(up), .lag(lag),
		.enc_a(enc_a), .enc_b(enc_b), .enc_index(enc_index), .busy(busy));

	// Clock and a cycle ceiling well above the planned run
	always #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			errors++;
			end_of_test();
		end
	end

	task end_of_test();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// One classic cycle; held until ack, released, then one idle cycle
	task wb(input bit w, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
		rq = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge sys_clk);
	endtask

	task rc(input string n, input logic [7:0] a, input logic [15:0] e);
		wb(1'b0, a, 32'h00000000);
		`CHK(n, e, rq[15:0])
	endtask

	// Sector borders sit 30 degrees either side of each multiple of 60
	function automatic int bd(input int k);
		return (`BCS_COUNTS_PER_ELEC * (2 * k + 1)) / 12;
	endfunction

	task brd(input int a, input int b);
		lo = 16'(a);
		hi = 16'(b);
		wb(1'b1, `BCS_REG_CMP_LO, {16'h0000, lo});
		wb(1'b1, `BCS_REG_CMP_HI, {16'h0000, hi});
	endtask

	// Step the encoder until n steps or the border event; decode needs slack
	task mv(input bit u, input int n);
		for (int i = 0; i < n; i++) begin
			stp <= 1'b1;
			up <= u;
			lag <= 4'($urandom % 6);
			@(posedge sys_clk);
			stp <= 1'b0;
			do @(posedge sys_clk); while (busy);
			repeat (4) @(posedge sys_clk);
			p = u ? p + 1 : p - 1;
			ev = (16'(p) == lo) || (16'(p) == hi);
			`CHK("pos_event", ev, pos_event)
			if (ev)
				break;
		end
	endtask

	// Gate on-time over two carrier periods for one sector word
	task pwm(input logic [2:0] s, input int f, input int pl, input bit ng);
		int h[3];
		int l[3];
		wb(1'b1, `BCS_REG_CTRL, ng ? 32'h00000011 : 32'h00000001);
		wb(1'b1, `BCS_REG_SECTOR, {29'h0, s});
		h = '{0, 0, 0};
		l = '{0, 0, 0};
		repeat (2000) begin
			@(posedge sys_clk);
			for (int k = 0; k < 3; k++) begin
				h[k] += gt[5 - 2 * k];
				l[k] += gt[4 - 2 * k];
			end
		end
		`CHK("float", 0, h[f] + l[f])
		`CHK("bipolar", 1'b1, h[pl] > 0 && l[pl] > 0)
		`CHK("polarity", !ng, h[pl] > l[pl])
		$display("test pwm %0h done", s);
	endtask

	initial begin
		void'($urandom(32'h5183));
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		// Reset values, a read-only and an unmapped place
		`CHK("gates", 6'h00, gt)
		rc("ctrl", `BCS_REG_CTRL, 16'h0000);
		rc("gain_p", `BCS_REG_GAIN_P, `BCS_GAIN_P_RESET);
		rc("gain_i", `BCS_REG_GAIN_I, `BCS_GAIN_I_RESET);
		rc("sample", `BCS_REG_SAMPLE, `BCS_SAMPLE_RESET);
		wb(1'b1, `BCS_REG_POS, 32'h00001234);
		wb(1'b1, 8'hFC, 32'h0000FFFF);
		rc("pos_ro", `BCS_REG_POS, 16'h0000);
		rc("unmapped", 8'hFC, 16'h0000);
		$display("test reset done");
		// Align, clear, then one electrical turn sector by sector
		wb(1'b1, `BCS_REG_SECTOR, 32'h00000006);
		wb(1'b1, `BCS_REG_CTRL, 32'h00000005);
		p = 0;
		for (int k = 0; k < 6; k++) begin
			brd(bd(k - 1), bd(k));
			mv(1'b1, 400);
			`CHK("border", bd(k), p)
			rc("pos", `BCS_REG_POS, 16'(p));
			wb(1'b0, `BCS_REG_STATUS, 32'h00000000);
			`CHK("evt_bit", 1'b1, rq[0])
			`CHK("dir_up", 1'b1, rq[1])
			wb(1'b1, `BCS_REG_STATUS, 32'h00000001);
			`CHK("cleared", 1'b0, pos_event)
			wb(1'b1, `BCS_REG_SECTOR, {29'h0, sq[(k + 1) % 6]});
		end
		$display("test turn done");
		// Turn back short of the lower border, then reach it
		brd(bd(4), bd(6));
		nr = 1 + $urandom % (bd(5) - bd(4) - 1);
		mv(1'b0, nr);
		wb(1'b0, `BCS_REG_STATUS, 32'h00000000);
		`CHK("dir_down", 1'b0, rq[1])
		`CHK("index", 1'b1, rq[2])
		mv(1'b0, 400);
		`CHK("back", bd(4), p)
		wb(1'b1, `BCS_REG_STATUS, 32'h00000001);
		$display("test reverse done");
		// Open loop duty, vector table and voltage sign
		wb(1'b1, `BCS_REG_SPD_REQ, 32'h00000320);
		pwm(3'h6, 1, 0, 1'b0);
		pwm(3'h6, 1, 0, 1'b1);
		pwm(3'h4, 2, 0, 1'b0);
		// Reset mid-run so the integrator and speed estimate start from zero
		rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		`CHK("gates_rst", 6'h00, gt)
		rc("status_rst", `BCS_REG_STATUS, 16'h0000);
		// Speed loop on a stalled rotor: duty climbs in integral steps
		wb(1'b1, `BCS_REG_SPD_REQ, 32'h0000000A);
		wb(1'b1, `BCS_REG_SAMPLE, 32'h00000014);
		wb(1'b1, `BCS_REG_GAIN_P, 32'h00000002);
		wb(1'b1, `BCS_REG_GAIN_I, 32'h00000001);
		wb(1'b1, `BCS_REG_CTRL, 32'h00000009);
		rc("spd_act", `BCS_REG_SPD_ACT, 16'h0000);
		last = 0;
		repeat (60) begin
			wb(1'b0, `BCS_REG_DUTY, 32'h00000000);
			`CHK("duty_step", 1'b1, rq[15:0] >= last && rq[15:0] % 10 == 0)
			last = rq[15:0];
		end
		`CHK("duty_rise", 1'b1, last >= 60)
		wb(1'b1, `BCS_REG_GAIN_P, 32'h000000C8);
		repeat (60) @(posedge sys_clk);
		rc("clamp", `BCS_REG_DUTY, `BCS_DUTY_MAX);
		$display("test speed loop done");
		end_of_test();
	end
endmodule // tb

bind bcs_commutator bcs_chk bcs_chk_i (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .enc_a(enc_a),
	.enc_b(enc_b), .enc_index(enc_index), .phase_a_high_switch(phase_a_high_switch),
	.phase_a_low_switch(phase_a_low_switch), .phase_b_high_switch(phase_b_high_switch),
	.phase_b_low_switch(phase_b_low_switch), .phase_c_high_switch(phase_c_high_switch),
	.phase_c_low_switch(phase_c_low_switch), .pos_event(pos_event));
